// file: hw/rrcc_pkg.sv
package rrcc_pkg;

  // ----------------------------------------
  // Counter bank
  // ----------------------------------------
  localparam int          N_CNT    = 12;        // 11 reversible + fast
  localparam int          FAST_IDX = 11;        // Fast counter slot
  localparam logic [15:0] BCD_MAX  = 16'h9999;  // Top of ring
  localparam logic [15:0] BCD_ZERO = 16'h0000;  // Bottom of ring

  // ----------------------------------------
  // Range table and results
  // ----------------------------------------
  localparam int          TBL_DEPTH = 1024;     // Table words
  localparam int          RES_BITS  = 256;      // One bit per range
  localparam int          RES_WORDS = 16;       // Result words
  localparam logic [9:0]  BASE_LAST = 10'h3FD;  // Base so T+2 fits
  localparam logic [15:0] PTR_LAST  = 16'h1023; // Last pointer, BCD

  // ----------------------------------------
  // Register word offsets
  // ----------------------------------------
  localparam logic [11:0] A_RST   = 12'h000;    // Reset bits
  localparam logic [11:0] A_DIR   = 12'h001;    // Direction bits
  localparam logic [11:0] A_SEL   = 12'h002;    // Compared counter
  localparam logic [11:0] A_BASE  = 12'h003;    // Table base word
  localparam logic [11:0] A_STAT  = 12'h004;    // Sticky status
  localparam logic [11:0] A_MASK  = 12'h005;    // Interrupt mask
  localparam logic [11:0] A_PTR   = 12'h006;    // Indirect pointer
  localparam logic [11:0] A_COUNT = 12'h007;    // Selected count
  localparam logic [11:0] A_RES0  = 12'h020;    // Result words
  localparam logic [11:0] A_TBL0  = 12'h400;    // Table memory

  // ----------------------------------------
  // Status bits
  // ----------------------------------------
  localparam int ST_ERR  = 0;                   // Error flag
  localparam int ST_PASS = 1;                   // Compare pass done
  localparam int ST_WRAP = 2;                   // Some counter wrapped
  localparam int ST_W    = 3;                   // Status width

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic {
    WALK_IDLE,
    WALK_RUN
  } rrcc_walk_t;

  typedef struct packed {
    logic [N_CNT-1:0]        rst_bits;          // Per-counter reset
    logic [N_CNT-1:0]        dir_bits;          // Per-counter down
    logic [3:0]              sel;               // Compared counter
    logic [9:0]              base;              // Table base index
    logic [ST_W-1:0]         stat;              // Sticky events
    logic [ST_W-1:0]         mask;              // Event enables
    logic [N_CNT-1:0]        in_prev;           // Last input level
    logic [N_CNT-1:0][15:0]  cnt;               // BCD counts
    rrcc_walk_t              walk;              // Compare walker
    logic [7:0]              k;                 // Range index
    logic [7:0]              n;                 // Last range index
    logic [15:0]             snap;              // Count compared
    logic                    hold;              // Pass may not write
    logic [RES_BITS-1:0]     res;               // Result bits
    logic [15:0]             rdata;             // Read data
    logic                    irq;               // Interrupt line
    logic                    err;               // Base invalid level
  } rrcc_state_t;

endpackage : rrcc_pkg

// file: hw/rrcc_top.sv
// Notes on behaviour
// [RULE_01] Counts wrap around within 0000 to 9999.
// [RULE_02] Count moves only on input rising edge.
// [RULE_03] Base word bits 7:0 give ranges minus one.
// [RULE_04] Range k bounds at base+2k+1, base+2k+2.
// [RULE_05] First bound above second means wrapping range.
// [RULE_06] Range k drives result bit k.
// [RULE_07] While reset on, compare as count zero.
// [RULE_08] Table edits take effect on later compares.
// [RULE_09] Reset bit holds count zero, ignores edges. The fast counter ignores edges but keeps its count until scan end.
// [RULE_10] Direction bit on counts down, off up.
// [RULE_11] Eleven counters, reset/direction bit per counter.
// [RULE_12] Only counters 500 to 511 are selectable.
// [RULE_13] Bounds must be BCD; never flagged.
// [RULE_14] Flag error when base+2 leaves table area.
// [RULE_15] Flag non-BCD or out-of-area pointer.
// [RULE_16] Fast counter uses same table compare.
// [RULE_17] Fast reset clears at scan end.
// [RULE_18] Fast results refresh only with compare enable.
// [RULE_19] Both range bounds are inclusive.
`timescale 1ns/1ps
module rrcc_top (
  // Clock, reset, enable
  input  wire logic         I_CLK,
  input  wire logic         I_RST_N,
  input  wire logic         I_CE,
  // Counting inputs and scan
  input  wire logic [10:0]  I_CNT_IN,
  input  wire logic         I_FAST_IN,
  input  wire logic         I_SCAN_END,
  input  wire logic         I_CMP_EN,
  // Register port
  input  wire logic [11:0]  I_ADDR,
  input  wire logic [15:0]  I_WDATA,
  input  wire logic         I_WR,
  input  wire logic         I_RD,
  output logic      [15:0]  O_RDATA,
  // Results and flags
  output logic      [255:0] O_RESULT,
  output logic              O_ERR,
  output logic              O_IRQ
);

  // ----------------------------------------
  // State and table memory
  // ----------------------------------------
  rrcc_pkg::rrcc_state_t s_ff;                  // Registered state
  rrcc_pkg::rrcc_state_t nxt_s;                 // Next state
  logic [15:0] tbl_mem [rrcc_pkg::TBL_DEPTH];   // Range table words
  logic [rrcc_pkg::N_CNT-1:0] cnt_in;           // All count inputs
  logic [rrcc_pkg::N_CNT-1:0][15:0] nxt_cnt;    // Stepped counts
  logic [rrcc_pkg::N_CNT-1:0] wrap_ev;          // Ring wrapped

  assign cnt_in = {I_FAST_IN, I_CNT_IN};

  // ----------------------------------------
  // BCD ring step
  // ----------------------------------------
  // Digit carry chain; 9999 up gives 0000, 0000 down gives 9999
  function automatic logic [15:0] bcd_step(input logic [15:0] v,
                                           input logic dn);
    logic [15:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    for (int d = 0; d < 4; d++) begin
      if (c) begin
        if (!dn && v[d*4+:4] == 4'h9) begin
          r[d*4+:4] = 4'h0;
        end else if (dn && v[d*4+:4] == 4'h0) begin
          r[d*4+:4] = 4'h9;
        end else begin
          r[d*4+:4] = dn ? v[d*4+:4] - 4'h1 : v[d*4+:4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcd_step

  // True when every nibble is a decimal digit
  function automatic logic is_bcd(input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    for (int d = 0; d < 4; d++) begin
      if (v[d*4+:4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : is_bcd

  // ----------------------------------------
  // Per-counter next count
  // ----------------------------------------
  // One slot per counter; slot 11 is the fast counter
  for (genvar i = 0; i < rrcc_pkg::N_CNT; i++) begin : g_cnt
    logic rise;                                 // Off-to-on edge
    assign rise = cnt_in[i] & ~s_ff.in_prev[i]; // see [RULE_02]
    always_comb begin
      nxt_cnt[i] = s_ff.cnt[i];
      wrap_ev[i] = 1'b0;
      if (i == rrcc_pkg::FAST_IDX) begin
        // Reset/disable waits for the scan end to clear
        if (s_ff.rst_bits[i] && I_SCAN_END) begin
          nxt_cnt[i] = rrcc_pkg::BCD_ZERO;      // see [RULE_17]
        end else if (rise && !s_ff.rst_bits[i]) begin
          nxt_cnt[i] = bcd_step(s_ff.cnt[i], s_ff.dir_bits[i]);
        end
      end else if (s_ff.rst_bits[i]) begin
        nxt_cnt[i] = rrcc_pkg::BCD_ZERO;        // see [RULE_09] [RULE_11]
      end else if (rise) begin
        nxt_cnt[i] = bcd_step(s_ff.cnt[i], s_ff.dir_bits[i]); // see [RULE_10] [RULE_01]
      end
      if (rise && !s_ff.rst_bits[i] && nxt_cnt[i] != s_ff.cnt[i]) begin // A reset to zero is no wrap
        wrap_ev[i] = (s_ff.dir_bits[i] && s_ff.cnt[i] == rrcc_pkg::BCD_ZERO) ||
                     (!s_ff.dir_bits[i] && s_ff.cnt[i] == rrcc_pkg::BCD_MAX);
      end
    end
  end

  // ----------------------------------------
  // Range compare of the current pair
  // ----------------------------------------
  logic [9:0]  lo_idx;                          // Address of first bound
  logic [15:0] lo_b;                            // First bound
  logic [15:0] hi_b;                            // Second bound
  logic        in_rng;                          // Count inside range
  logic        fast_sel;                        // Fast counter compared

  // Bounds are taken straight from the table each step, so edits
  // land on the next range visited. Indexes wrap at table end.
  assign lo_idx = s_ff.base + {1'b0, s_ff.k, 1'b1}; // see [RULE_04] [RULE_08]
  assign lo_b   = tbl_mem[lo_idx];
  assign hi_b   = tbl_mem[lo_idx + 10'h001];
  // BCD bounds compare as plain binary; no digit check here
  assign in_rng = (lo_b <= hi_b) ?
                  (s_ff.snap >= lo_b && s_ff.snap <= hi_b) :
                  (s_ff.snap >= lo_b || s_ff.snap <= hi_b); // see [RULE_05] [RULE_19] [RULE_13]
  assign fast_sel = (s_ff.sel == 4'(rrcc_pkg::FAST_IDX));

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [rrcc_pkg::ST_W-1:0] set_ev;          // Events this cycle
    logic [rrcc_pkg::ST_W-1:0] clr_ev;          // W1C this cycle
    logic                      wr;              // Accepted write
    set_ev = '0;
    clr_ev = '0;
    wr     = I_WR;
    nxt_s  = s_ff;
    nxt_s.in_prev = cnt_in;
    nxt_s.cnt     = nxt_cnt;
    if (|wrap_ev) begin
      set_ev[rrcc_pkg::ST_WRAP] = 1'b1;
    end

    // Register writes
    if (wr) begin
      unique case (I_ADDR)
        rrcc_pkg::A_RST:  nxt_s.rst_bits = I_WDATA[rrcc_pkg::N_CNT-1:0];
        rrcc_pkg::A_DIR:  nxt_s.dir_bits = I_WDATA[rrcc_pkg::N_CNT-1:0];
        rrcc_pkg::A_SEL: begin
          // Numbers past the fast counter cannot be selected
          if (I_WDATA[3:0] <= 4'(rrcc_pkg::FAST_IDX)) begin
            nxt_s.sel = I_WDATA[3:0];          // see [RULE_12] [RULE_16]
          end
        end
        rrcc_pkg::A_BASE: begin
          nxt_s.base = I_WDATA[9:0];
          if (I_WDATA[9:0] > rrcc_pkg::BASE_LAST || I_WDATA[15:10] != 6'h00) begin
            set_ev[rrcc_pkg::ST_ERR] = 1'b1;    // see [RULE_14]
          end
        end
        rrcc_pkg::A_STAT: clr_ev = I_WDATA[rrcc_pkg::ST_W-1:0];
        rrcc_pkg::A_MASK: nxt_s.mask = I_WDATA[rrcc_pkg::ST_W-1:0];
        rrcc_pkg::A_PTR: begin
          if (!is_bcd(I_WDATA) || I_WDATA > rrcc_pkg::PTR_LAST) begin
            set_ev[rrcc_pkg::ST_ERR] = 1'b1;    // see [RULE_15]
          end
        end
        default: ;
      endcase
    end

    // Base level error blocks the walker
    nxt_s.err = (nxt_s.base > rrcc_pkg::BASE_LAST); // see [RULE_14]

    // Compare walker: one range per cycle
    unique case (s_ff.walk)
      rrcc_pkg::WALK_IDLE: begin
        if (!s_ff.err) begin
          // Reset counters are compared as zero
          nxt_s.snap = s_ff.rst_bits[s_ff.sel] ? rrcc_pkg::BCD_ZERO :
                       s_ff.cnt[s_ff.sel];     // see [RULE_07] [RULE_17] [RULE_16]
          nxt_s.n    = tbl_mem[s_ff.base][7:0]; // see [RULE_03]
          nxt_s.hold = fast_sel && !I_CMP_EN;   // see [RULE_18]
          nxt_s.k    = 8'h00;
          nxt_s.walk = rrcc_pkg::WALK_RUN;
        end
      end
      rrcc_pkg::WALK_RUN: begin
        if (!s_ff.hold) begin
          nxt_s.res[s_ff.k] = in_rng;           // see [RULE_06]
        end
        if (s_ff.k == s_ff.n || s_ff.err) begin
          set_ev[rrcc_pkg::ST_PASS] = !s_ff.hold;
          nxt_s.walk = rrcc_pkg::WALK_IDLE;
        end else begin
          nxt_s.k = s_ff.k + 8'h01;
        end
      end
    endcase

    // Sticky status: a new event beats its own clear
    nxt_s.stat = (s_ff.stat & ~clr_ev) | set_ev;
    nxt_s.irq  = |(nxt_s.stat & nxt_s.mask);

    // Read data stands only in the cycle after the strobe
    nxt_s.rdata = 16'h0000;
    if (I_RD) begin
      if (I_ADDR >= rrcc_pkg::A_TBL0) begin
        nxt_s.rdata = tbl_mem[I_ADDR[9:0]];
      end else if (I_ADDR >= rrcc_pkg::A_RES0 &&
                   I_ADDR < rrcc_pkg::A_RES0 + 12'(rrcc_pkg::RES_WORDS)) begin
        nxt_s.rdata = s_ff.res[I_ADDR[3:0]*16+:16];
      end else begin
        unique case (I_ADDR)
          rrcc_pkg::A_RST:   nxt_s.rdata = {4'h0, s_ff.rst_bits};
          rrcc_pkg::A_DIR:   nxt_s.rdata = {4'h0, s_ff.dir_bits};
          rrcc_pkg::A_SEL:   nxt_s.rdata = {12'h000, s_ff.sel};
          rrcc_pkg::A_BASE:  nxt_s.rdata = {6'h00, s_ff.base};
          rrcc_pkg::A_STAT:  nxt_s.rdata = {13'h0000, s_ff.stat};
          rrcc_pkg::A_MASK:  nxt_s.rdata = {13'h0000, s_ff.mask};
          rrcc_pkg::A_COUNT: nxt_s.rdata = s_ff.cnt[s_ff.sel];
          default:           nxt_s.rdata = 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Clock enable low freezes every flop
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_ff <= '0;
    end else if (I_CE) begin
      s_ff <= nxt_s;
    end
  end

  // Table memory write port; no reset, software loads it
  always_ff @(posedge I_CLK) begin
    if (I_CE && I_WR && I_ADDR >= rrcc_pkg::A_TBL0) begin
      tbl_mem[I_ADDR[9:0]] <= I_WDATA;          // see [RULE_08]
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign O_RDATA  = s_ff.rdata;
  assign O_RESULT = s_ff.res;
  assign O_ERR    = s_ff.err;
  assign O_IRQ    = s_ff.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_digits;
    @(posedge I_CLK) disable iff (!I_RST_N)
    is_bcd(s_ff.cnt[0]) && is_bcd(s_ff.cnt[rrcc_pkg::FAST_IDX]);
  endproperty
  a_digits: assert property (p_digits) // see [RULE_01]
    else $error("count left the decimal ring");

  property p_no_edge;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && !(I_CNT_IN[0] && !s_ff.in_prev[0]) && !s_ff.rst_bits[0])
      |=> $stable(s_ff.cnt[0]);
  endproperty
  a_no_edge: assert property (p_no_edge) // see [RULE_02]
    else $error("count moved without a rising edge");

  property p_rst;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && s_ff.rst_bits[3]) |=> (s_ff.cnt[3] == 16'h0000);
  endproperty
  a_rst: assert property (p_rst) // see [RULE_09]
    else $error("reset counter not at zero");

  property p_down_wrap;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && !s_ff.rst_bits[0] && s_ff.dir_bits[0] && I_CNT_IN[0] &&
     !s_ff.in_prev[0] && s_ff.cnt[0] == 16'h0000) |=> (s_ff.cnt[0] == 16'h9999);
  endproperty
  a_down_wrap: assert property (p_down_wrap) // see [RULE_10]
    else $error("down count from zero did not give 9999");

  property p_snap_zero;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && s_ff.walk == rrcc_pkg::WALK_IDLE && !s_ff.err &&
     s_ff.rst_bits[s_ff.sel]) |=> (s_ff.snap == 16'h0000);
  endproperty
  a_snap_zero: assert property (p_snap_zero) // see [RULE_07]
    else $error("reset counter compared as nonzero");

  property p_fast_hold;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (s_ff.walk == rrcc_pkg::WALK_RUN && s_ff.hold) |=> $stable(s_ff.res);
  endproperty
  a_fast_hold: assert property (p_fast_hold) // see [RULE_18]
    else $error("results changed without compare enable");

  property p_fast_clr;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && I_SCAN_END && s_ff.rst_bits[rrcc_pkg::FAST_IDX])
      |=> (s_ff.cnt[rrcc_pkg::FAST_IDX] == 16'h0000);
  endproperty
  a_fast_clr: assert property (p_fast_clr) // see [RULE_17]
    else $error("fast counter not cleared at scan end");

  property p_bad_base;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && s_ff.err) |=> (s_ff.walk == rrcc_pkg::WALK_IDLE);
  endproperty
  a_bad_base: assert property (p_bad_base) // see [RULE_14]
    else $error("walker ran with bad base");

  property p_bad_ptr;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && I_WR && I_ADDR == rrcc_pkg::A_PTR && !is_bcd(I_WDATA))
      |=> s_ff.stat[rrcc_pkg::ST_ERR];
  endproperty
  a_bad_ptr: assert property (p_bad_ptr) // see [RULE_15]
    else $error("non-BCD pointer not flagged");

  property p_hit;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && s_ff.walk == rrcc_pkg::WALK_RUN && !s_ff.hold && in_rng)
      |=> s_ff.res[$past(s_ff.k)];
  endproperty
  a_hit: assert property (p_hit) // see [RULE_06]
    else $error("in-range result bit not set");

endmodule : rrcc_top

// file: tb/rrcc_pulse_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// Counting pulse source
// ----------------------------------------
module rrcc_pulse_src (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // One request bit per slot, slots 0..11 only
  input  wire logic [11:0] i_req,
  // Counting levels toward the block
  output logic      [11:0] o_lvl
);
  // Each request gives one high cycle; the bench spaces requests,
  // so a level is always low for a cycle between two edges
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_lvl <= 12'h000;
    end else begin
      o_lvl <= i_req;
    end
  end
endmodule : rrcc_pulse_src

// file: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t value mismatch got %0h exp %0h", $time, a, b); end end
module tb_top;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic         i_clk, i_rst_n, i_cmp_en, i_scan_end;
  logic [11:0]  i_addr, req, lvl;
  logic [15:0]  i_wdata, v;
  logic         i_wr, i_rd;
  logic [15:0]  o_rdata;
  logic [255:0] o_result;
  logic         o_err, o_irq;
  int           n_mismatch = 0;   // Mismatches seen
  int           tests_run  = 0;   // Comparisons made
  logic         i_ce;             // Clock enable toward the block
  rrcc_top i_dut (.I_CLK(i_clk), .I_RST_N(i_rst_n), .I_CE(i_ce),
    .I_CNT_IN(lvl[10:0]), .I_FAST_IN(lvl[11]), .I_SCAN_END(i_scan_end),
    .I_CMP_EN(i_cmp_en), .I_ADDR(i_addr), .I_WDATA(i_wdata), .I_WR(i_wr),
    .I_RD(i_rd), .O_RDATA(o_rdata), .O_RESULT(o_result), .O_ERR(o_err),
    .O_IRQ(o_irq));
  rrcc_pulse_src i_src (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .o_lvl(lvl));
  // ----------------------------------------
  // Bus and helper tasks
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a);
    @(posedge i_clk);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd
  task automatic chk_rd(input logic [11:0] a, input logic [15:0] e);
    rd(a);
    `CHK(v, e)
  endtask : chk_rd
  // One spaced pulse per count
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge i_clk); req[idx] <= 1'b1;
      @(posedge i_clk); req[idx] <= 1'b0;
      @(posedge i_clk);
    end
    repeat (2) @(posedge i_clk);
  endtask : pulse
  // Two full passes of a 17-range table, n+2 cycles each
  task automatic wait_pass();
    repeat (40) @(posedge i_clk);
    #1;
  endtask : wait_pass
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    // Park the walker on a bad base while word 0 gets a range count:
    // an unwritten count word would start a pass of unknown length
    wr(rrcc_pkg::A_BASE, 16'h03FE);
    wr(rrcc_pkg::A_TBL0, 16'h0000);
    wr(rrcc_pkg::A_BASE, 16'h0000);
    wr(rrcc_pkg::A_STAT, 16'h0001);
    chk_rd(rrcc_pkg::A_SEL, 16'h0000);
    chk_rd(rrcc_pkg::A_COUNT, 16'h0000);
    chk_rd(12'h010, 16'h0000);
    `CHK(o_irq, 1'b0)
    `CHK(o_err, 1'b0)
  endtask : t_reset
  // Slots 0 to 10 up twice, then down once through each one's own direction bit
  task automatic t_each();
    for (int i = 0; i < 11; i++) begin
      wr(rrcc_pkg::A_SEL, 16'(i));
      pulse(i, 2);
      wr(rrcc_pkg::A_DIR, 16'(1 << i));
      pulse(i, 1);
      chk_rd(rrcc_pkg::A_COUNT, 16'h0001);
    end
    wr(rrcc_pkg::A_DIR, 16'h0000);
    wr(rrcc_pkg::A_RST, 16'h0008);
    pulse(3, 2);
    wr(rrcc_pkg::A_SEL, 16'h0003);
    chk_rd(rrcc_pkg::A_COUNT, 16'h0000);
    wr(rrcc_pkg::A_RST, 16'h0000);
    pulse(3, 1);
    chk_rd(rrcc_pkg::A_COUNT, 16'h0001);
    // Clock enable low: the block must not see this pulse at all
    @(posedge i_clk); i_ce <= 1'b0;
    pulse(3, 1);
    @(posedge i_clk); i_ce <= 1'b1;
    chk_rd(rrcc_pkg::A_COUNT, 16'h0001);
  endtask : t_each
  // Ring wrap both ways, sticky status and masked interrupt
  task automatic t_wrap();
    wr(rrcc_pkg::A_SEL, 16'h0000);
    wr(rrcc_pkg::A_DIR, 16'h0001);
    pulse(0, 2);
    chk_rd(rrcc_pkg::A_COUNT, 16'h9999);
    wr(rrcc_pkg::A_DIR, 16'h0000);
    pulse(0, 1);
    chk_rd(rrcc_pkg::A_COUNT, 16'h0000);
    rd(rrcc_pkg::A_STAT);
    `CHK(v[2], 1'b1)
    `CHK(o_irq, 1'b0)
    wr(rrcc_pkg::A_MASK, 16'h0004);
    @(posedge i_clk); #1;
    `CHK(o_irq, 1'b1)
    wr(rrcc_pkg::A_STAT, 16'h0004);
    @(posedge i_clk); #1;
    `CHK(o_irq, 1'b0)
  endtask : t_wrap
  // Slot 1 holds 1; seventeen ranges, the last crossing zero
  task automatic t_compare();
    logic [15:0] lo, hi;
    wr(rrcc_pkg::A_SEL, 16'h0001);
    // Count word goes in before the base points at it
    wr(rrcc_pkg::A_TBL0 + 12'h010, 16'h0010);
    wr(rrcc_pkg::A_BASE, 16'h0010);
    for (int k = 0; k < 17; k++) begin
      case (k)
        0:       begin lo = 16'h0001; hi = 16'h0001; end
        1:       begin lo = 16'h0002; hi = 16'h0005; end
        2:       begin lo = 16'h0000; hi = 16'h0000; end
        16:      begin lo = 16'h9998; hi = 16'h0002; end
        default: begin lo = 16'h0500; hi = 16'h0600; end
      endcase
      wr(rrcc_pkg::A_TBL0 + 12'h011 + 12'(2 * k), lo);
      wr(rrcc_pkg::A_TBL0 + 12'h012 + 12'(2 * k), hi);
    end
    wait_pass();
    `CHK(o_result[16:0], 17'h10001)
    chk_rd(rrcc_pkg::A_RES0 + 12'h001, 16'h0001);
    wr(rrcc_pkg::A_RST, 16'h0002);
    wait_pass();
    `CHK(o_result[16:0], 17'h10004)
    wr(rrcc_pkg::A_RST, 16'h0000);
    wr(rrcc_pkg::A_TBL0 + 12'h013, 16'h0000);
    wr(rrcc_pkg::A_TBL0 + 12'h014, 16'h0003);
    wait_pass();
    `CHK(o_result[16:0], 17'h10006)
    pulse(1, 1);
    wait_pass();
    `CHK(o_result[16:0], 17'h10003)
  endtask : t_compare
  // Base past the last legal index, bad pointers
  task automatic t_errors();
    wr(rrcc_pkg::A_BASE, 16'h03FE);
    @(posedge i_clk); #1;
    `CHK(o_err, 1'b1)
    // Give the last legal base a defined range count first
    wr(rrcc_pkg::A_TBL0 + 12'h3FD, 16'h0000);
    wr(rrcc_pkg::A_BASE, 16'h03FD);
    @(posedge i_clk); #1;
    `CHK(o_err, 1'b0)
    wr(rrcc_pkg::A_STAT, 16'h0001);
    chk_rd(rrcc_pkg::A_STAT, 16'h0002);
    wr(rrcc_pkg::A_PTR, 16'h0A00);
    rd(rrcc_pkg::A_STAT);
    `CHK(v[0], 1'b1)
    wr(rrcc_pkg::A_STAT, 16'h0001);
    wr(rrcc_pkg::A_PTR, 16'h1023);
    rd(rrcc_pkg::A_STAT);
    `CHK(v[0], 1'b0)
    wr(rrcc_pkg::A_PTR, 16'h1024);
    rd(rrcc_pkg::A_STAT);
    `CHK(v[0], 1'b1)
    wr(rrcc_pkg::A_BASE, 16'h0010);
  endtask : t_errors
  // Fast slot: compare, enable gating, reset at scan end
  task automatic t_fast();
    wr(rrcc_pkg::A_SEL, 16'h000B);
    pulse(11, 1);
    wait_pass();
    `CHK(o_result[2:0], 3'b011)
    @(posedge i_clk); i_cmp_en <= 1'b0;
    pulse(11, 1);
    chk_rd(rrcc_pkg::A_COUNT, 16'h0002);
    wr(rrcc_pkg::A_RST, 16'h0800);
    wait_pass();
    `CHK(o_result[2:0], 3'b011)
    @(posedge i_clk); i_cmp_en <= 1'b1;
    wait_pass();
    `CHK(o_result[2:0], 3'b110)
    // Reset alone keeps the count until the scan ends
    chk_rd(rrcc_pkg::A_COUNT, 16'h0002);
    @(posedge i_clk); i_scan_end <= 1'b1;
    @(posedge i_clk); i_scan_end <= 1'b0;
    wr(rrcc_pkg::A_RST, 16'h0000);
    chk_rd(rrcc_pkg::A_COUNT, 16'h0000);
  endtask : t_fast
  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // Free-running 40 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Main sequence
  initial begin
    i_rst_n = 1'b0; i_cmp_en = 1'b1; i_scan_end = 1'b0; req = 12'h000;
    i_addr = 12'h000; i_wdata = 16'h0000; i_wr = 1'b0; i_rd = 1'b0;
    i_ce = 1'b1;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_each();
    t_wrap();
    t_compare();
    t_errors();
    t_fast();
    report_and_stop();
  end
  // Hang guard, well past the fewer than a thousand cycles needed
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_top
